// [hdl/mcsr_map.vh]
// Offsets, field positions and reset values of the core special registers
`ifndef MCSR_MAP_VH
`define MCSR_MAP_VH
`define MCSR_STACK_TOP_ADDR     8'h81
`define MCSR_PTR0_LOW_ADDR      8'h82
`define MCSR_PTR0_HIGH_ADDR     8'h83
`define MCSR_PTR1_LOW_ADDR      8'h84
`define MCSR_PTR1_HIGH_ADDR     8'h85
`define MCSR_POWER_CTL_ADDR     8'h87
`define MCSR_PTR_SELECT_ADDR    8'h92
`define MCSR_STATUS_ADDR        8'hD0
`define MCSR_ACCUM_ADDR         8'hE0
`define MCSR_MULT_AUX_ADDR      8'hF0
`define MCSR_ST_ODD_BIT         0
`define MCSR_ST_USER1_BIT       1
`define MCSR_ST_OVF_BIT         2
`define MCSR_ST_BANK_LO         3
`define MCSR_ST_BANK_HI         4
`define MCSR_ST_USER0_BIT       5
`define MCSR_ST_HALF_BIT        6
`define MCSR_ST_CARRY_BIT       7
`define MCSR_PC_BAUD_BIT        7
`define MCSR_PC_CODEWR_BIT      4
`define MCSR_PC_RW_MASK         8'hFC
`define MCSR_STACK_TOP_RST      8'h07
`define MCSR_BYTE_RST           8'h00
`define MCSR_FLAG_RST           1'h0
`define MCSR_BANK_RST           2'h0
`define MCSR_WORD_RST           16'h0000
`endif

// [hdl/mcsr_core_regs.v]
// Core special registers: accumulator, aux, status, stack, pointers, power control
//
// Summary of operation
// - Odd-ones flag tracks accumulator parity
// - Odd-ones flag ignores software writes
// - Bank field selects working register base
// - Status bit 7 holds carry
// - Status bit 6 holds half carry
// - Status bit 2 holds overflow
// - Status bits 5,1 free user flags
// - Stack pointer pre-increments on push/call
// - Stack pointer post-decrements on pop/return
// - Select bit picks active data pointer
// - Pointer 0 low/high at 0x82/0x83
// - Pointer 1 low/high at 0x84/0x85
// - Active pointer gives 16-bit address, writable whole
// - Accumulator at 0xE0 holds operand/result
// - Aux byte at 0xF0 for multiply/divide
// - Power bit 7 selects serial baud doubling
// - Power bit 4 enables code write mode
// - Power bits 1,0 read zero
// - Power bits 6,5,3,2 plain spare flags
// - Only 0xD0, 0xE0 and 0xF0 are bit addressable
// - Low 32 bytes form four banks
`timescale 1ns/1ps
`include "mcsr_map.vh"
module mcsr_core_regs (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // Special register byte access
    input  wire [7:0]  i_sfr_addr,
    input  wire        i_sfr_wr,
    input  wire [7:0]  i_sfr_wdata,
    input  wire        i_sfr_rd,
    output reg  [7:0]  o_sfr_rdata,
    output reg         o_sfr_hit,
    // Special register bit access
    input  wire [7:0]  i_bit_addr,
    input  wire        i_bit_wr,
    input  wire        i_bit_wdata,
    output reg         o_bit_rdata,
    output reg         o_bit_hit,
    // Execution core: accumulator and aux results
    input  wire        i_acc_ld,
    input  wire [7:0]  i_acc_val,
    input  wire        i_aux_ld,
    input  wire [7:0]  i_aux_val,
    // Execution core: arithmetic flags
    input  wire        i_cy_ld,
    input  wire        i_cy_val,
    input  wire        i_ac_ld,
    input  wire        i_ac_val,
    input  wire        i_ov_ld,
    input  wire        i_ov_val,
    // Execution core: stack
    input  wire        i_stack_push,
    input  wire        i_stack_pop,
    // Execution core: active pointer word
    input  wire        i_dptr_ld,
    input  wire [15:0] i_dptr_val,
    input  wire        i_dptr_inc,
    // Values to the core
    output reg  [7:0]  o_acc,
    output reg  [7:0]  o_aux,
    output reg  [7:0]  o_status,
    output reg  [7:0]  o_stack_top,
    output reg  [7:0]  o_stack_wr_addr,
    output reg  [15:0] o_dptr,
    output reg  [4:0]  o_bank_base,
    output reg         o_carry,
    output reg         o_baud_double,
    output reg         o_code_write_en
);
    reg  [7:0]  acc_ff;
    reg  [7:0]  aux_ff;
    reg         cy_ff;
    reg         ac_ff;
    reg         ov_ff;
    reg         f0_ff;
    reg         f1_ff;
    reg  [1:0]  bank_ff;
    reg  [7:0]  sp_ff;
    wire [15:0] ptr0_word;
    wire [15:0] ptr1_word;
    wire [15:0] nxt_ptr0;
    wire [15:0] nxt_ptr1;
    reg         sel_ff;
    reg  [7:0]  pc_ff;

    reg  [7:0]  nxt_acc;
    reg  [7:0]  nxt_aux;
    reg  [7:0]  nxt_sp;
    reg  [7:0]  nxt_pc;
    reg         nxt_sel;
    reg  [7:0]  nxt_st;
    reg  [7:0]  st_now;
    reg  [7:0]  rd_mux;
    reg         rd_hit;
    reg  [7:0]  bit_reg;
    reg         bit_ok;
    wire [7:0]  bit_byte;
    wire [2:0]  bit_pos;
    wire        nxt_par;

    assign bit_byte = {i_bit_addr[7:3], 3'h0};
    assign bit_pos  = i_bit_addr[2:0];

    // Status byte as stored, parity from live accumulator
    always @* begin
        st_now = 8'h00;
        st_now[`MCSR_ST_CARRY_BIT] = cy_ff;
        st_now[`MCSR_ST_HALF_BIT]  = ac_ff;
        st_now[`MCSR_ST_USER0_BIT] = f0_ff;
        st_now[`MCSR_ST_BANK_HI]   = bank_ff[1];
        st_now[`MCSR_ST_BANK_LO]   = bank_ff[0];
        st_now[`MCSR_ST_OVF_BIT]   = ov_ff;
        st_now[`MCSR_ST_USER1_BIT] = f1_ff;
        st_now[`MCSR_ST_ODD_BIT]   = ^acc_ff;
    end

    // Byte read decode
    always @* begin
        rd_hit = 1'h1;
        case (i_sfr_addr)
            `MCSR_ACCUM_ADDR:      rd_mux = acc_ff;
            `MCSR_MULT_AUX_ADDR:   rd_mux = aux_ff;
            `MCSR_STATUS_ADDR:     rd_mux = st_now;
            `MCSR_STACK_TOP_ADDR:  rd_mux = sp_ff;
            `MCSR_PTR0_LOW_ADDR:   rd_mux = ptr0_word[7:0];
            `MCSR_PTR0_HIGH_ADDR:  rd_mux = ptr0_word[15:8];
            `MCSR_PTR1_LOW_ADDR:   rd_mux = ptr1_word[7:0];
            `MCSR_PTR1_HIGH_ADDR:  rd_mux = ptr1_word[15:8];
            `MCSR_POWER_CTL_ADDR:  rd_mux = pc_ff & `MCSR_PC_RW_MASK;
            `MCSR_PTR_SELECT_ADDR: rd_mux = {7'h00, sel_ff};
            default: begin
                rd_mux = 8'h00;
                rd_hit = 1'h0;
            end
        endcase
    end

    // Bit access picks only bit-addressable bytes
    always @* begin
        bit_ok = 1'h1;
        case (bit_byte)
            `MCSR_ACCUM_ADDR:    bit_reg = acc_ff;
            `MCSR_MULT_AUX_ADDR: bit_reg = aux_ff;
            `MCSR_STATUS_ADDR:   bit_reg = st_now;
            default: begin
                bit_reg = 8'h00;
                bit_ok  = 1'h0;
            end
        endcase
    end

    // Data pointer 0, active while the select bit is low
    mcsr_dptr_pair #(
        .LOW_ADDR   (`MCSR_PTR0_LOW_ADDR),
        .HIGH_ADDR  (`MCSR_PTR0_HIGH_ADDR)
    ) u_ptr0 (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_sfr_addr (i_sfr_addr),
        .i_sfr_wr   (i_sfr_wr),
        .i_sfr_wdata(i_sfr_wdata),
        .i_active   (~sel_ff),
        .i_word_ld  (i_dptr_ld),
        .i_word_val (i_dptr_val),
        .i_word_inc (i_dptr_inc),
        .o_word     (ptr0_word),
        .o_nxt_word (nxt_ptr0)
    );

    // Data pointer 1, active while the select bit is high
    mcsr_dptr_pair #(
        .LOW_ADDR   (`MCSR_PTR1_LOW_ADDR),
        .HIGH_ADDR  (`MCSR_PTR1_HIGH_ADDR)
    ) u_ptr1 (
        .i_clk      (i_clk),
        .i_srst     (i_srst),
        .i_sfr_addr (i_sfr_addr),
        .i_sfr_wr   (i_sfr_wr),
        .i_sfr_wdata(i_sfr_wdata),
        .i_active   (sel_ff),
        .i_word_ld  (i_dptr_ld),
        .i_word_val (i_dptr_val),
        .i_word_inc (i_dptr_inc),
        .o_word     (ptr1_word),
        .o_nxt_word (nxt_ptr1)
    );

    // Next values: software first, core results override
    always @* begin
        nxt_acc = acc_ff;
        nxt_aux = aux_ff;
        nxt_st  = st_now;
        nxt_sp  = sp_ff;
        nxt_pc  = pc_ff;
        nxt_sel = sel_ff;
        if (i_sfr_wr) begin
            case (i_sfr_addr)
                `MCSR_ACCUM_ADDR:      nxt_acc = i_sfr_wdata;
                `MCSR_MULT_AUX_ADDR:   nxt_aux = i_sfr_wdata;
                `MCSR_STATUS_ADDR:     nxt_st  = i_sfr_wdata;
                `MCSR_STACK_TOP_ADDR:  nxt_sp  = i_sfr_wdata;
                `MCSR_POWER_CTL_ADDR:  nxt_pc  = i_sfr_wdata & `MCSR_PC_RW_MASK;
                `MCSR_PTR_SELECT_ADDR: nxt_sel = i_sfr_wdata[0];
                default: nxt_sel = sel_ff;
            endcase
        end
        if (i_bit_wr && bit_ok) begin
            case (bit_byte)
                `MCSR_ACCUM_ADDR:    nxt_acc[bit_pos] = i_bit_wdata;
                `MCSR_MULT_AUX_ADDR: nxt_aux[bit_pos] = i_bit_wdata;
                `MCSR_STATUS_ADDR:   nxt_st[bit_pos]  = i_bit_wdata;
                default:             ;
            endcase
        end
        if (i_acc_ld)
            nxt_acc = i_acc_val;
        if (i_aux_ld)
            nxt_aux = i_aux_val;
        if (i_cy_ld)
            nxt_st[`MCSR_ST_CARRY_BIT] = i_cy_val;
        if (i_ac_ld)
            nxt_st[`MCSR_ST_HALF_BIT] = i_ac_val;
        if (i_ov_ld)
            nxt_st[`MCSR_ST_OVF_BIT] = i_ov_val;
        if (i_stack_push)
            nxt_sp = sp_ff + 8'h01;
        else if (i_stack_pop)
            nxt_sp = sp_ff - 8'h01;
    end

    assign nxt_par = ^nxt_acc;

    // Byte registers of the core
    always @(posedge i_clk) begin
        if (i_srst) begin
            acc_ff <= `MCSR_BYTE_RST;
            aux_ff <= `MCSR_BYTE_RST;
            sp_ff  <= `MCSR_STACK_TOP_RST;
            pc_ff  <= `MCSR_BYTE_RST;
            sel_ff <= `MCSR_FLAG_RST;
        end else begin
            acc_ff <= nxt_acc;
            aux_ff <= nxt_aux;
            sp_ff  <= nxt_sp;
            pc_ff  <= nxt_pc;
            sel_ff <= nxt_sel;
        end
    end

    // Status flags apart from parity
    always @(posedge i_clk) begin
        if (i_srst) begin
            cy_ff   <= `MCSR_FLAG_RST;
            ac_ff   <= `MCSR_FLAG_RST;
            ov_ff   <= `MCSR_FLAG_RST;
            f0_ff   <= `MCSR_FLAG_RST;
            f1_ff   <= `MCSR_FLAG_RST;
            bank_ff <= `MCSR_BANK_RST;
        end else begin
            cy_ff   <= nxt_st[`MCSR_ST_CARRY_BIT];
            ac_ff   <= nxt_st[`MCSR_ST_HALF_BIT];
            ov_ff   <= nxt_st[`MCSR_ST_OVF_BIT];
            f0_ff   <= nxt_st[`MCSR_ST_USER0_BIT];
            f1_ff   <= nxt_st[`MCSR_ST_USER1_BIT];
            bank_ff <= nxt_st[`MCSR_ST_BANK_HI:`MCSR_ST_BANK_LO];
        end
    end

    // Read answers one cycle later: bytes after the strobe, bits after the address
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_sfr_rdata <= `MCSR_BYTE_RST;
            o_sfr_hit   <= `MCSR_FLAG_RST;
            o_bit_rdata <= `MCSR_FLAG_RST;
            o_bit_hit   <= `MCSR_FLAG_RST;
        end else begin
            o_sfr_rdata <= i_sfr_rd ? rd_mux : 8'h00;
            o_sfr_hit   <= i_sfr_rd & rd_hit;
            o_bit_rdata <= bit_ok & bit_reg[bit_pos];
            o_bit_hit   <= bit_ok;
        end
    end

    // Mirrors to the core, equal to the registers after the edge
    always @(posedge i_clk) begin
        if (i_srst) begin
            o_acc           <= `MCSR_BYTE_RST;
            o_aux           <= `MCSR_BYTE_RST;
            o_status        <= `MCSR_BYTE_RST;
            o_stack_top     <= `MCSR_STACK_TOP_RST;
            o_stack_wr_addr <= `MCSR_STACK_TOP_RST + 8'h01;
            o_dptr          <= `MCSR_WORD_RST;
            o_bank_base     <= {`MCSR_BANK_RST, 3'h0};
            o_carry         <= `MCSR_FLAG_RST;
            o_baud_double   <= `MCSR_FLAG_RST;
            o_code_write_en <= `MCSR_FLAG_RST;
        end else begin
            o_acc           <= nxt_acc;
            o_aux           <= nxt_aux;
            // Parity follows the accumulator only
            o_status        <= {nxt_st[7:1], nxt_par};
            o_stack_top     <= nxt_sp;
            o_stack_wr_addr <= nxt_sp + 8'h01;
            o_dptr          <= nxt_sel ? nxt_ptr1 : nxt_ptr0;
            o_bank_base     <= {nxt_st[`MCSR_ST_BANK_HI:`MCSR_ST_BANK_LO], 3'h0};
            o_carry         <= nxt_st[`MCSR_ST_CARRY_BIT];
            o_baud_double   <= nxt_pc[`MCSR_PC_BAUD_BIT];
            o_code_write_en <= nxt_pc[`MCSR_PC_CODEWR_BIT];
        end
    end
endmodule // mcsr_core_regs

// One 16-bit data pointer: two software bytes plus core word updates
module mcsr_dptr_pair #(
    parameter [7:0] LOW_ADDR  = `MCSR_PTR0_LOW_ADDR,
    parameter [7:0] HIGH_ADDR = `MCSR_PTR0_HIGH_ADDR
) (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_srst,
    // Software byte writes
    input  wire [7:0]  i_sfr_addr,
    input  wire        i_sfr_wr,
    input  wire [7:0]  i_sfr_wdata,
    // Core word updates, taken only while active
    input  wire        i_active,
    input  wire        i_word_ld,
    input  wire [15:0] i_word_val,
    input  wire        i_word_inc,
    // Stored word and its next value
    output wire [15:0] o_word,
    output reg  [15:0] o_nxt_word
);
    reg  [7:0]  low_ff;
    reg  [7:0]  high_ff;
    reg  [15:0] step_word;

    // High byte upper address, low byte lower address
    assign o_word = {high_ff, low_ff};

    // Word load beats step; core update beats same-cycle byte write
    always @* begin
        step_word  = i_word_ld ? i_word_val : (o_word + 16'h0001);
        o_nxt_word = o_word;
        if (i_sfr_wr && (i_sfr_addr == LOW_ADDR))
            o_nxt_word[7:0] = i_sfr_wdata;
        if (i_sfr_wr && (i_sfr_addr == HIGH_ADDR))
            o_nxt_word[15:8] = i_sfr_wdata;
        if (i_active && (i_word_ld || i_word_inc))
            o_nxt_word = step_word;
    end

    // Pointer byte storage
    always @(posedge i_clk) begin
        if (i_srst) begin
            low_ff  <= `MCSR_BYTE_RST;
            high_ff <= `MCSR_BYTE_RST;
        end else begin
            low_ff  <= o_nxt_word[7:0];
            high_ff <= o_nxt_word[15:8];
        end
    end
endmodule // mcsr_dptr_pair

// [testbench/mcsr_core_regs_properties.sv]
// Concurrent checks on the core special register ports
`timescale 1ns/1ps
module mcsr_core_regs_properties (
    // Clock, reset and access strobes
    input logic       i_clk, i_srst, i_sfr_wr, i_sfr_rd, i_bit_wr, i_acc_ld,
    input logic       i_stack_push, i_stack_pop,
    // Byte access and mirrors
    input logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata, o_acc, o_status,
    input logic [7:0] o_stack_top, o_stack_wr_addr,
    input logic [4:0] o_bank_base,
    input logic       o_sfr_hit, o_code_write_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);
    property p_parity; o_status[0] == ^o_acc; endproperty
    a_parity: assert property (p_parity) else $error("parity flag off");
    property p_push; i_stack_push |=> o_stack_top == $past(o_stack_top) + 8'h01; endproperty
    a_push: assert property (p_push) else $error("push step wrong");
    property p_pop;
        i_stack_pop && !i_stack_push |=> o_stack_top == $past(o_stack_top) - 8'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop step wrong");
    property p_wr_addr; o_stack_wr_addr == o_stack_top + 8'h01; endproperty
    a_wr_addr: assert property (p_wr_addr) else $error("stack write address wrong");
    property p_bank; o_bank_base == {o_status[4:3], 3'h0}; endproperty
    a_bank: assert property (p_bank) else $error("bank base wrong");
    property p_acc_wr;
        i_sfr_wr && i_sfr_addr == 8'hE0 && !i_acc_ld && !i_bit_wr |=> o_acc == $past(i_sfr_wdata);
    endproperty
    a_acc_wr: assert property (p_acc_wr) else $error("accumulator write lost");
    property p_unmapped; i_sfr_rd && i_sfr_addr == 8'h80 |=> !o_sfr_hit && o_sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
    property p_pc_zero; i_sfr_rd && i_sfr_addr == 8'h87 |=> o_sfr_rdata[1:0] == 2'h0; endproperty
    a_pc_zero: assert property (p_pc_zero) else $error("power low bits not zero");
    property p_cw_hold; !(i_sfr_wr && i_sfr_addr == 8'h87) |=> $stable(o_code_write_en);
    endproperty
    a_cw_hold: assert property (p_cw_hold) else $error("code write moved alone");
    c_push: cover property (i_stack_push ##1 i_stack_push);
    c_pop: cover property (i_stack_pop && !i_stack_push);
    c_hit: cover property (i_sfr_rd ##1 o_sfr_hit);
endmodule // mcsr_core_regs_properties
bind mcsr_core_regs mcsr_core_regs_properties u_props (.i_clk, .i_srst, .i_sfr_wr, .i_sfr_rd,
    .i_bit_wr, .i_acc_ld, .i_stack_push, .i_stack_pop, .i_sfr_addr, .i_sfr_wdata, .o_sfr_rdata,
    .o_acc, .o_status, .o_stack_top, .o_stack_wr_addr, .o_bank_base, .o_sfr_hit, .o_code_write_en);

// [testbench/tb.sv]
// Self-checking bench for the core special registers
`timescale 1ns/1ps
module tb;
    logic        i_clk = '0, i_srst = 1'h1, i_sfr_wr = '0, i_sfr_rd = '0, i_bit_wr = '0;
    logic        i_bit_wdata = '0, i_acc_ld = '0, i_aux_ld = '0, i_cy_ld = '0, i_cy_val = '0;
    logic        i_ac_ld = '0, i_ac_val = '0, i_ov_ld = '0, i_ov_val = '0, i_stack_push = '0;
    logic        i_stack_pop = '0, i_dptr_ld = '0, i_dptr_inc = '0;
    logic [7:0]  i_sfr_addr = '0, i_sfr_wdata = '0, i_bit_addr = '0, i_acc_val = '0, i_aux_val = '0;
    logic [15:0] i_dptr_val = '0;
    wire  [7:0]  o_sfr_rdata, o_acc, o_aux, o_status, o_stack_top, o_stack_wr_addr;
    wire  [15:0] o_dptr;
    wire  [4:0]  o_bank_base;
    wire         o_sfr_hit, o_bit_rdata, o_bit_hit, o_carry, o_baud_double, o_code_write_en;
    int          miscompares = 0;
    int          tests_run = 0;
    int          b;
    always #2 i_clk = ~i_clk;
    mcsr_core_regs dut (.*);
    task automatic tick;
        @(posedge i_clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: saw %h want %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'h1;
        tick;
        i_sfr_wr = 1'h0;
        tick;
    endtask
    // Expected value carries the hit flag in bit 8
    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        i_sfr_addr = a;
        i_sfr_rd = 1'h1;
        tick;
        i_sfr_rd = 1'h0;
        chk({o_sfr_hit, o_sfr_rdata}, e);
        tick;
    endtask
    task automatic wrap_up;
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (2000) @(posedge i_clk);
        miscompares++;
        wrap_up;
    end
    initial begin
        repeat (8) tick;
        i_srst = 1'h0;
        rd(8'h81, 9'h107);
        chk(o_stack_wr_addr, 8'h08);
        rd(8'hD0, 9'h100);
        rd(8'h80, 9'h000);
        $display("reset test done");
        wr(8'hE0, 8'h07);
        rd(8'hD0, 9'h101);
        wr(8'hD0, 8'hFE);
        rd(8'hD0, 9'h1FF);
        chk(o_carry, 1'h1);
        wr(8'hE0, 8'h03);
        wr(8'hD0, 8'h01);
        rd(8'hD0, 9'h100);
        for (b = 0; b < 4; b++) begin
            wr(8'hD0, 8'(b * 8));
            chk(o_bank_base, 16'(b * 8));
        end
        {i_cy_ld, i_cy_val, i_ac_ld, i_ac_val, i_ov_ld, i_ov_val} = 6'h3F;
        wr(8'hD0, 8'h00);
        {i_cy_ld, i_ac_ld, i_ov_ld} = 3'h0;
        rd(8'hD0, 9'h1C4);
        i_acc_ld = 1'h1;
        i_acc_val = 8'h01;
        tick;
        i_acc_ld = 1'h0;
        tick;
        chk(o_status, 8'hC5);
        $display("status test done");
        i_stack_push = 1'h1;
        repeat (2) tick;
        chk(o_stack_top, 8'h09);
        i_stack_pop = 1'h1;
        tick;
        i_stack_push = 1'h0;
        tick;
        i_stack_pop = 1'h0;
        chk(o_stack_top, 8'h09);
        wr(8'h81, 8'h20);
        i_stack_pop = 1'h1;
        tick;
        i_stack_pop = 1'h0;
        rd(8'h81, 9'h11F);
        $display("stack test done");
        wr(8'h82, 8'h11);
        wr(8'h83, 8'h22);
        wr(8'h84, 8'h33);
        wr(8'h85, 8'h44);
        chk(o_dptr, 16'h2211);
        wr(8'h92, 8'hFF);
        rd(8'h92, 9'h101);
        chk(o_dptr, 16'h4433);
        i_dptr_val = 16'hBEEF;
        i_dptr_ld = 1'h1;
        tick;
        i_dptr_ld = 1'h0;
        i_dptr_inc = 1'h1;
        tick;
        i_dptr_inc = 1'h0;
        rd(8'h84, 9'h1F0);
        rd(8'h85, 9'h1BE);
        wr(8'h92, 8'h00);
        chk(o_dptr, 16'h2211);
        $display("pointer test done");
        wr(8'h87, 8'h90);
        rd(8'h87, 9'h190);
        chk({o_baud_double, o_code_write_en}, 2'h3);
        wr(8'h87, 8'h6C);
        rd(8'h87, 9'h16C);
        chk({o_baud_double, o_code_write_en}, 2'h0);
        wr(8'hF0, 8'hA5);
        rd(8'hF0, 9'h1A5);
        i_aux_val = 8'h5A;
        i_aux_ld = 1'h1;
        tick;
        i_aux_ld = 1'h0;
        chk(o_aux, 8'h5A);
        $display("power test done");
        i_bit_addr = 8'hE7;
        i_bit_wdata = 1'h1;
        i_bit_wr = 1'h1;
        tick;
        i_bit_wr = 1'h0;
        tick;
        chk({o_bit_hit, o_bit_rdata, o_acc}, 10'h381);
        i_bit_addr = 8'h8A;
        i_bit_wr = 1'h1;
        tick;
        i_bit_wr = 1'h0;
        tick;
        chk({o_bit_hit, o_stack_top}, 9'h01F);
        $display("bit test done");
        wrap_up;
    end
endmodule // tb
